// ### testbench.sv
// Self-checking bench for the timer interrupt flag block
`timescale 1ns/1ns
`include "tif_map.svh"
module testbench import tif_pkg::*;;
    localparam logic [17:0] A_EN1 = {`TIF_IDX_EN_ONE, 2'b00};
    localparam logic [17:0] A_EN2 = {`TIF_IDX_EN_TWO, 2'b00};
    localparam logic [17:0] A_RQ1 = {`TIF_IDX_REQ_ONE, 2'b00};
    localparam logic [17:0] A_RQ2 = {`TIF_IDX_REQ_TWO, 2'b00};
    localparam logic [17:0] A_BAD = 18'h00010;
    logic         clk_sys = 1'b0;
    logic         rstn    = 1'b0;
    logic [17:0]  awaddr  = '0;
    logic [17:0]  araddr  = '0;
    logic         awvalid = 1'b0;
    logic         wvalid  = 1'b0;
    logic         bready  = 1'b0;
    logic         arvalid = 1'b0;
    logic         rready  = 1'b0;
    logic [31:0]  wdata   = '0;
    logic [3:0]   wstrb   = '0;
    logic         step_a  = 1'b0;
    logic         step_c  = 1'b0;
    logic         down_c  = 1'b0;
    tif_evt_one_t evt_one = '0;
    tif_evt_two_t evt_two = '0;
    logic         awready, wready, bvalid, arready, rvalid, irq_any;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    logic [7:0]   ta_cnt, tc_cnt;
    tif_irq_t     irq;
    int           errors  = 0;
    int           checked = 0;

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    tif_timer_model model (.clk_sys(clk_sys), .rstn(rstn), .step_a(step_a), .step_c(step_c),
        .down_c(down_c), .timer_a_count(ta_cnt), .timer_c_count(tc_cnt));

    tif_irq_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_a_count(ta_cnt), .timer_c_count(tc_cnt), .evt_one(evt_one), .evt_two(evt_two),
        .irq(irq), .irq_any(irq_any));

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Handshakes are judged mid-cycle, where the readies have settled
    task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ta, tw, tb;
        int   n;
        r = 2'b11;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int   n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            errors++;
            tally_and_finish();
        end
    endtask

    // Plain write expecting OKAY, and a read compared to a byte
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        cmp({30'h0, r}, {30'h0, `TIF_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er = `TIF_RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        cmp(d, {24'h0, e});
        cmp({30'h0, r}, {30'h0, er});
    endtask

    task automatic irq_chk(input logic [7:0] one, input logic [7:0] two);
        @(negedge clk_sys);
        cmp({16'h0, irq}, {16'h0, one, two});
        cmp({31'h0, irq_any}, {31'h0, |{one, two}});
    endtask

    task automatic t_reset_and_map();
        logic [1:0] r;
        rd_chk(A_EN1, 8'h00);
        rd_chk(A_EN2, 8'h00);
        rd_chk(A_RQ1, 8'h00);
        rd_chk(A_RQ2, 8'h00);
        irq_chk(8'h00, 8'h00);
        axi_wr(A_BAD, 8'hff, 4'h1, r);
        cmp({30'h0, r}, {30'h0, `TIF_RESP_SLVERR});
        rd_chk(A_BAD, 8'h00, `TIF_RESP_SLVERR);
        wr(A_EN1, 8'hff);
        rd_chk(A_EN1, `TIF_MASK_EN_ONE);
        wr(A_EN2, 8'hff);
        rd_chk(A_EN2, `TIF_MASK_EN_TWO);
        irq_chk(8'h00, 8'h00);
        wr(A_EN1, 8'h00);
        wr(A_EN2, 8'h00);
    endtask

    // Timer A wraps while its enable is off, then the enable opens the request
    task automatic t_timer_a();
        repeat (2) begin
            @(posedge clk_sys);
            step_a <= 1'b1;
            @(posedge clk_sys);
            step_a <= 1'b0;
        end
        rd_chk(A_RQ1, 8'h80);
        irq_chk(8'h00, 8'h00);
        wr(A_EN1, 8'h20);
        irq_chk(8'h80, 8'h00);
        wr(A_RQ1, 8'hff);
        rd_chk(A_RQ1, 8'h80);
        wr(A_RQ1, 8'h7f, 4'h0);
        rd_chk(A_RQ1, 8'h80);
        wr(A_RQ1, 8'h7f);
        rd_chk(A_RQ1, 8'h00);
        irq_chk(8'h00, 8'h00);
        // Count up to ff, then wrap in the very cycle a clearing write lands: the set must win
        @(posedge clk_sys);
        step_a <= 1'b1;
        repeat (255) @(posedge clk_sys);
        step_a <= 1'b0;
        fork
            wr(A_RQ1, 8'h7f);
            begin
                @(posedge clk_sys);
                step_a <= 1'b1;
                @(posedge clk_sys);
                step_a <= 1'b0;
            end
        join
        rd_chk(A_RQ1, 8'h80);
        irq_chk(8'h80, 8'h00);
        wr(A_RQ1, 8'h7f);
        rd_chk(A_RQ1, 8'h00);
        irq_chk(8'h00, 8'h00);
    endtask

    // Timer C underflows first with its enable off, then overflows back
    task automatic t_timer_c();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            step_c <= 1'b1;
            down_c <= (i == 0);
            @(posedge clk_sys);
            step_c <= 1'b0;
            rd_chk(A_RQ2, 8'h80);
            if (i == 0) begin
                irq_chk(8'h00, 8'h00);
                wr(A_EN2, 8'h02);
            end
            irq_chk(8'h00, 8'h80);
            wr(A_RQ2, 8'h7f);
            rd_chk(A_RQ2, 8'h00);
        end
    endtask

    // Every event line sets its own flag and nothing else
    task automatic t_events();
        int pos2 [6] = '{0, 2, 3, 4, 5, 6};
        logic [7:0] b;
        wr(A_EN1, 8'h1f);
        wr(A_EN2, 8'h7d);
        for (int i = 0; i < 11; i++) begin
            b = 8'h01 << (i < 5 ? i : pos2[i-5]);
            @(posedge clk_sys);
            if (i < 5) evt_one <= tif_evt_one_t'(5'h01 << i);
            else evt_two <= tif_evt_two_t'(6'h01 << (i - 5));
            @(posedge clk_sys);
            evt_one <= '0;
            evt_two <= '0;
            rd_chk(i < 5 ? A_RQ1 : A_RQ2, b);
            irq_chk(i < 5 ? b : 8'h00, i < 5 ? 8'h00 : b);
            wr(i < 5 ? A_RQ1 : A_RQ2, ~b);
            rd_chk(i < 5 ? A_RQ1 : A_RQ2, 8'h00);
        end
    endtask

    // Reset for four cycles, then each scenario in turn
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_and_map();
        t_timer_a();
        t_timer_c();
        t_events();
        tally_and_finish();
    end
endmodule

// ### tif_flag_reg.sv
// Sticky request flags: hardware sets, software writes zero to clear
`timescale 1ns/1ns
`include "tif_map.svh"
module tif_flag_reg
    import tif_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [7:0] set,
    input  wire logic       wr,
    input  wire logic [7:0] wr_data,
    output logic [7:0]      flags
);

    logic [7:0] next_flags;

    // A one written keeps the flag; a set in the same cycle beats the clear
    always_comb begin
        next_flags = wr ? (flags & wr_data) : flags;
        next_flags = (next_flags | set) & MASK;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags <= `TIF_RST_REQ;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// ### tif_irq_ctrl.sv
// Timer interrupt request flags and enables behind an AXI4-Lite slave
// What this block does
// - Enable-one bit 5 lets the timer A request through when 1, blocks at 0.
// - Request-one flags set on timer A, lines four, three, one, zero, event counter.
// - Timer A flag, request-one bit 7, sets when its counter wraps ff to 00.
// - Writing 0 to the timer A flag clears it.
// - Enable-two bit 1 lets the timer C request through when 1.
// - Request-two flags set on direct transition, converter, timers G, FH, FL, C, counter.
// - Timer C flag, request-two bit 7, sets on ff to 00 or 00 to ff.
// - Writing 0 to the timer C flag clears it.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tif_map.svh"
module tif_irq_ctrl
    import tif_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // AXI4-Lite write address
    input  wire logic [`TIF_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    // AXI4-Lite write response
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // AXI4-Lite read address
    input  wire logic [`TIF_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    // AXI4-Lite read data
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // Timer counters and event pulses, same clock
    input  wire logic [7:0]             timer_a_count,
    input  wire logic [7:0]             timer_c_count,
    input  wire tif_evt_one_t           evt_one,
    input  wire tif_evt_two_t           evt_two,
    // Requests toward the core
    output tif_irq_t                    irq,
    output logic                        irq_any
);

    // Byte address of a register index
    function automatic logic [`TIF_ADDR_W-1:0] idx_addr(input logic [15:0] idx);
        idx_addr = {idx, 2'b00};
    endfunction

    // Address decode shared by reads and writes
    function automatic tif_sel_t addr_sel(input logic [`TIF_ADDR_W-1:0] a);
        if (a == idx_addr(`TIF_IDX_EN_ONE)) begin
            addr_sel = TIF_SEL_EN_ONE;
        end else if (a == idx_addr(`TIF_IDX_EN_TWO)) begin
            addr_sel = TIF_SEL_EN_TWO;
        end else if (a == idx_addr(`TIF_IDX_REQ_ONE)) begin
            addr_sel = TIF_SEL_REQ_ONE;
        end else if (a == idx_addr(`TIF_IDX_REQ_TWO)) begin
            addr_sel = TIF_SEL_REQ_TWO;
        end else begin
            addr_sel = TIF_SEL_NONE;
        end
    endfunction

    logic [`TIF_ADDR_W-1:0] wr_addr;
    logic [7:0]             wr_data;
    logic                   wr_lane;
    logic                   aw_full;
    logic                   w_full;
    logic                   do_wr;
    tif_sel_t               wr_sel;
    tif_sel_t               rd_sel;
    logic [7:0]             en_one;
    logic [7:0]             en_two;
    logic [7:0]             req_one;
    logic [7:0]             req_two;
    logic [7:0]             set_one;
    logic [7:0]             set_two;
    logic                   ta_wrap;
    logic                   tc_wrap;
    logic                   wr_req1;
    logic                   wr_req2;
    logic [7:0]             rd_byte;

    // Protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot};

    // Timer A counts up only
    tif_wrap_det #(
        .DOWN_TOO (1'b0)
    ) u_ta_wrap (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .count   (timer_a_count),
        .wrap    (ta_wrap)
    );

    // Timer C wraps either way
    tif_wrap_det #(
        .DOWN_TOO (1'b1)
    ) u_tc_wrap (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .count   (timer_c_count),
        .wrap    (tc_wrap)
    );

    // One write at a time: address and data may come in either order
    assign awready = !aw_full && !bvalid;
    assign wready  = !w_full && !bvalid;
    assign do_wr   = aw_full && w_full;
    assign wr_sel  = addr_sel(wr_addr);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_full <= 1'b0;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_full <= 1'b1;
            wr_addr <= awaddr;
        end else if (do_wr) begin
            aw_full <= 1'b0;
        end
    end

    // Only the low byte lane reaches the 8-bit registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            w_full  <= 1'b0;
            wr_data <= 8'h00;
            wr_lane <= 1'b0;
        end else if (wvalid && wready) begin
            w_full  <= 1'b1;
            wr_data <= wdata[7:0];
            wr_lane <= wstrb[0];
        end else if (do_wr) begin
            w_full  <= 1'b0;
        end
    end

    // Response one cycle after both halves are held; unmapped gets SLVERR
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= `TIF_RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (wr_sel == TIF_SEL_NONE) ? `TIF_RESP_SLVERR : `TIF_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Enable registers, written only when lane 0 is strobed
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_one <= `TIF_RST_EN;
            en_two <= `TIF_RST_EN;
        end else if (do_wr && wr_lane) begin
            if (wr_sel == TIF_SEL_EN_ONE) begin
                en_one <= wr_data & `TIF_MASK_EN_ONE;
            end
            if (wr_sel == TIF_SEL_EN_TWO) begin
                en_two <= wr_data & `TIF_MASK_EN_TWO;
            end
        end
    end

    // Flag writes: zero clears, one keeps
    assign wr_req1 = do_wr && wr_lane && wr_sel == TIF_SEL_REQ_ONE;
    assign wr_req2 = do_wr && wr_lane && wr_sel == TIF_SEL_REQ_TWO;

    // Hardware set sources in flag bit order
    always_comb begin
        set_one = {ta_wrap, 2'b00, evt_one};
        set_two = {tc_wrap, evt_two.direct_transition, evt_two.adc_done,
                   evt_two.timer_g, evt_two.timer_fh, evt_two.timer_fl,
                   1'b0, evt_two.async_event_counter};
    end

    tif_flag_reg #(
        .MASK (`TIF_MASK_REQ_ONE)
    ) u_req_one (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (set_one),
        .wr      (wr_req1),
        .wr_data (wr_data),
        .flags   (req_one)
    );

    tif_flag_reg #(
        .MASK (`TIF_MASK_REQ_TWO)
    ) u_req_two (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (set_two),
        .wr      (wr_req2),
        .wr_data (wr_data),
        .flags   (req_two)
    );

    // Requests gated by their enables; timer A and C enables sit off their flag bits
    always_comb begin
        irq.one = req_one & {en_one[`TIF_BIT_TA_EN], 2'b00, en_one[4:0]};
        irq.two = req_two & {en_two[`TIF_BIT_TC_EN], en_two[6:2], 1'b0, en_two[0]};
        irq_any = |{irq.one, irq.two};
    end

    // Read side: data registered at the address handshake
    assign arready = !rvalid;
    assign rd_sel  = addr_sel(araddr);

    always_comb begin
        unique case (rd_sel)
            TIF_SEL_EN_ONE:  rd_byte = en_one;
            TIF_SEL_EN_TWO:  rd_byte = en_two;
            TIF_SEL_REQ_ONE: rd_byte = req_one;
            TIF_SEL_REQ_TWO: rd_byte = req_two;
            default:         rd_byte = 8'h00;
        endcase
    end

    // Reads have no side effects, so a flag is never lost to a status poll
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `TIF_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_byte};
            rresp  <= (rd_sel == TIF_SEL_NONE) ? `TIF_RESP_SLVERR : `TIF_RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_ta_set_wrap: assert property (ta_wrap |=> req_one[`TIF_BIT_TA_FLAG])
        else $error("timer A wrap did not set its flag");

    chk_ta_zero_clr: assert property (wr_req1 && !wr_data[`TIF_BIT_TA_FLAG] && !ta_wrap
        |=> !req_one[`TIF_BIT_TA_FLAG])
        else $error("timer A flag not cleared by a zero write");

    chk_tc_set_wrap: assert property (tc_wrap |=> req_two[`TIF_BIT_TC_FLAG])
        else $error("timer C wrap did not set its flag");

    chk_tc_zero_clr: assert property (wr_req2 && !wr_data[`TIF_BIT_TC_FLAG] && !tc_wrap
        |=> !req_two[`TIF_BIT_TC_FLAG])
        else $error("timer C flag not cleared by a zero write");

    chk_one_no_set: assert property (wr_req1 && wr_data[`TIF_BIT_TA_FLAG]
        && !req_one[`TIF_BIT_TA_FLAG] && !ta_wrap |=> !req_one[`TIF_BIT_TA_FLAG])
        else $error("writing one set a request flag");

    chk_set_wins_clr: assert property (wr_req1 && !wr_data[`TIF_BIT_TA_FLAG] && ta_wrap
        |=> req_one[`TIF_BIT_TA_FLAG])
        else $error("clear beat a simultaneous set");

    chk_ta_gate_en: assert property ($rose(en_one[`TIF_BIT_TA_EN]) && $past(req_one[`TIF_BIT_TA_FLAG])
        && req_one[`TIF_BIT_TA_FLAG] |-> irq.one[`TIF_BIT_TA_FLAG])
        else $error("enabled timer A flag gave no request");

    chk_tc_gate_off: assert property (!en_two[`TIF_BIT_TC_EN] |-> !irq.two[`TIF_BIT_TC_FLAG])
        else $error("timer C request passed while disabled");

    chk_irq_cause: assert property (irq_any |-> (|(req_one | req_two)) && (|(en_one | en_two)))
        else $error("request without flag and enable");

    chk_ext_set: assert property (evt_one.ext_line_zero |=> req_one[0] && !irq.two[1])
        else $error("line zero event did not set its flag");

    chk_adc_set: assert property (evt_two.adc_done |=> req_two[5] ##1 !req_two[1])
        else $error("converter event did not set its flag");

    chk_b_after_wr: assert property (do_wr |-> ##`TIF_B_LAT bvalid)
        else $error("write response missing");

    chk_b_hold_resp: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");

    chk_r_hold_data: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before rready");

    cov_ta_irq: cover property (ta_wrap ##1 irq.one[`TIF_BIT_TA_FLAG]);
    cov_tc_under: cover property (timer_c_count == `TIF_CNT_TOP && tc_wrap);
    cov_clr_tc: cover property (wr_req2 && !wr_data[`TIF_BIT_TC_FLAG] ##1 !req_two[`TIF_BIT_TC_FLAG]);

endmodule

// ### tif_map.svh
// Register map, field positions, reset values and timing counts of the timer interrupt flag block
`ifndef TIF_MAP_SVH
`define TIF_MAP_SVH

// Byte-address width of the register bus
`define TIF_ADDR_W      18

// Register indices; the byte address is four times the index
`define TIF_IDX_EN_ONE  16'hfff3
`define TIF_IDX_EN_TWO  16'hfff4
`define TIF_IDX_REQ_ONE 16'hfff6
`define TIF_IDX_REQ_TWO 16'hfff7

// Field positions
`define TIF_BIT_TA_FLAG 7
`define TIF_BIT_TA_EN   5
`define TIF_BIT_TC_FLAG 7
`define TIF_BIT_TC_EN   1

// Implemented bits; the rest read as zero
`define TIF_MASK_EN_ONE  8'h3f
`define TIF_MASK_EN_TWO  8'h7f
`define TIF_MASK_REQ_ONE 8'h9f
`define TIF_MASK_REQ_TWO 8'hfd

// Reset values
`define TIF_RST_EN  8'h00
`define TIF_RST_REQ 8'h00

// Counter wrap end points
`define TIF_CNT_TOP 8'hff
`define TIF_CNT_BOT 8'h00

// Bus answers
`define TIF_RESP_OKAY   2'b00
`define TIF_RESP_SLVERR 2'b10

// Cycles from both write halves being held (do_wr) to bvalid
`define TIF_B_LAT 1

`endif

// ### tif_pkg.sv
// Types shared by the timer interrupt flag block
package tif_pkg;

    // Request-one event pulses, in flag bit order 4..0
    typedef struct packed {
        logic ext_line_four;
        logic ext_line_three;
        logic async_event_counter_line;
        logic ext_line_one;
        logic ext_line_zero;
    } tif_evt_one_t;

    // Request-two event pulses other than timer C
    typedef struct packed {
        logic direct_transition;
        logic adc_done;
        logic timer_g;
        logic timer_fh;
        logic timer_fl;
        logic async_event_counter;
    } tif_evt_two_t;

    // Gated requests toward the core, one bit per flag
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } tif_irq_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        TIF_SEL_EN_ONE,
        TIF_SEL_EN_TWO,
        TIF_SEL_REQ_ONE,
        TIF_SEL_REQ_TWO,
        TIF_SEL_NONE
    } tif_sel_t;

endpackage

// ### tif_timer_model.sv
// Timer A and timer C counter model that feeds the flag block
`timescale 1ns/1ns
module tif_timer_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       step_a,
    input  wire logic       step_c,
    input  wire logic       down_c,
    output logic [7:0]      timer_a_count,
    output logic [7:0]      timer_c_count
);
    // Timer A counts up only; starts just below the top so two steps wrap it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timer_a_count <= 8'hfe;
        end else if (step_a) begin
            timer_a_count <= timer_a_count + 8'h01;
        end
    end

    // Timer C counts either way, so one step down from zero underflows
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timer_c_count <= 8'h00;
        end else if (step_c) begin
            timer_c_count <= down_c ? timer_c_count - 8'h01 : timer_c_count + 8'h01;
        end
    end
endmodule

// ### tif_wrap_det.sv
// Detects an 8-bit counter wrapping over its top or bottom
`timescale 1ns/1ns
`include "tif_map.svh"
module tif_wrap_det
    import tif_pkg::*;
#(
    parameter bit DOWN_TOO = 1'b0
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [7:0] count,
    output logic            wrap
);

    logic [7:0] prev;
    logic       primed;

    // Previous value; primed blocks a false wrap against the reset value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev   <= `TIF_CNT_BOT;
            primed <= 1'b0;
        end else begin
            prev   <= count;
            primed <= 1'b1;
        end
    end

    // Overflow top to bottom, and underflow when asked for
    always_comb begin
        wrap = primed && prev == `TIF_CNT_TOP && count == `TIF_CNT_BOT;
        if (DOWN_TOO && primed && prev == `TIF_CNT_BOT && count == `TIF_CNT_TOP) begin
            wrap = 1'b1;
        end
    end

endmodule
